// ---- slsp_pkg.sv ----
// Constants for the strap latch and status pin block
`default_nettype none
package slsp_pkg;
  // Clock and frame-sync timing
  localparam int CLK_PERIOD_NS = 50;
  localparam int FS8K_PERIOD_NS = 125000;
  localparam int FS2K_PERIOD_NS = 500000;
  localparam int FS8K_CYCLES = FS8K_PERIOD_NS / CLK_PERIOD_NS;
  localparam int FS2K_CYCLES = FS2K_PERIOD_NS / CLK_PERIOD_NS;

  // Register byte offsets
  localparam logic [7:0] OFS_INPUT_A_CFG = 8'h00;
  localparam logic [7:0] OFS_INPUT_B_CFG = 8'h04;
  localparam logic [7:0] OFS_OUT_FREQ_CFG = 8'h08;
  localparam logic [7:0] OFS_MASTER_CFG_H = 8'h0C;
  localparam logic [7:0] OFS_FRAME_PULSE_CFG = 8'h10;
  localparam logic [7:0] OFS_MASTER_CFG_J = 8'h14;
  localparam logic [7:0] OFS_MASTER_CFG_A = 8'h18;
  localparam logic [7:0] OFS_GP_IO_CONTROL = 8'h1C;
  localparam logic [7:0] OFS_GP_IO_STATUS = 8'h20;
  localparam logic [7:0] OFS_MASTER_STATUS_B = 8'h24;
  localparam logic [7:0] OFS_IRQ_STATUS = 8'h28;
  localparam logic [7:0] OFS_IRQ_MASK = 8'h2C;
  localparam logic [7:0] OFS_STRAP_VIEW = 8'h30;

  // Field positions
  localparam int POS_FREQ_CODE = 0;
  localparam int POS_SE_FREQ = 0;
  localparam int POS_DIFF_FREQ = 4;
  localparam int POS_SIG_FORMAT = 0;
  localparam int POS_P8K_INVERT = 0;
  localparam int POS_P8K_PULSE = 1;
  localparam int POS_P2K_INVERT = 2;
  localparam int POS_P2K_PULSE = 3;
  localparam int POS_REF_FAIL_PIN_EN = 0;
  localparam int POS_LOCK_PIN_EN = 0;
  localparam int POS_GP_DIR = 0;
  localparam int POS_GP_OUT = 4;
  localparam int POS_REF_FAILED = 0;
  localparam int POS_DPLL_LOCKED = 1;
  localparam int POS_EV_REF_FAIL = 0;
  localparam int POS_EV_LOCK_CHANGE = 1;
  localparam int POS_VIEW_IN = 0;
  localparam int POS_VIEW_SE = 4;
  localparam int POS_VIEW_DIFF = 8;

  // Values after reset
  localparam logic [1:0] RST_SIG_FORMAT = 2'h0;
  localparam logic [3:0] RST_FRAME_PULSE_CFG = 4'h0;
  localparam logic RST_REF_FAIL_PIN_EN = 1'b0;
  localparam logic RST_LOCK_PIN_EN = 1'b0;
  localparam logic [2:0] RST_GP_DIR = 3'h0;
  localparam logic [2:0] RST_GP_OUT = 3'h0;
  localparam logic [1:0] RST_IRQ_MASK = 2'h0;
  // Strap codes seen with the pins left open (pull resistors)
  localparam logic [2:0] OPEN_SE_FREQ_CODE = 3'h3;
  localparam logic [2:0] OPEN_DIFF_FREQ_CODE = 3'h4;
endpackage : slsp_pkg
`default_nettype wire

// ---- slsp_fs_if.sv ----
// Control and output bundle of one frame-sync generator
`default_nettype none
interface slsp_fs_if;
  logic ce;
  logic invert;
  logic pulse_mode;
  logic sync_out;
  modport gen (input ce, input invert, input pulse_mode, output sync_out);
  modport ctl (output ce, output invert, output pulse_mode, input sync_out);
endinterface : slsp_fs_if
`default_nettype wire

// ---- slsp_frame_gen.sv ----
// Frame-sync generator: square clock or one-cycle pulse, optional inversion
`default_nettype none
module slsp_frame_gen #(
  parameter int PERIOD_CYCLES = 2500
) (
  // Clock and reset
  input wire logic i_clk,
  input wire logic i_reset,
  // Control and output
  slsp_fs_if.gen fs
);
  localparam int CW = $clog2(PERIOD_CYCLES);
  localparam logic [CW-1:0] LAST = CW'(PERIOD_CYCLES - 1);
  localparam logic [CW-1:0] HALF = CW'(PERIOD_CYCLES / 2);

  if (PERIOD_CYCLES < 2 || (PERIOD_CYCLES % 2) != 0) begin : g_chk
    $error("PERIOD_CYCLES must be even and at least 2");
  end

  logic [CW-1:0] cnt_r;
  logic [CW-1:0] cnt_nxt;
  logic out_r;
  logic out_nxt;
  logic raw;

  always_comb begin
    cnt_nxt = cnt_r;
    out_nxt = out_r;
    raw = 1'b0;
    if (fs.ce) begin
      cnt_nxt = (cnt_r == LAST) ? '0 : cnt_r + 1'b1;
      // Pulse mode gives one clock-wide pulse at the start of each period
      raw = fs.pulse_mode ? (cnt_nxt == '0) : (cnt_nxt < HALF);
      out_nxt = raw ^ fs.invert;
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_reset) begin
      cnt_r <= '0;
      out_r <= 1'b0;
    end else begin
      cnt_r <= cnt_nxt;
      out_r <= out_nxt;
    end
  end

  assign fs.sync_out = out_r;
endmodule : slsp_frame_gen
`default_nettype wire

// ---- slsp_strap_pins.sv ----
// Strap latch, shared status pins, GPIO, reference select and frame syncs
// How it works
// - Reset holds every register except the pin synchronisers at its default for as long as reset stays asserted.
// - Source switch high selects input clock A, low selects input clock B.
// - Input-frequency straps load both input config frequency fields at release.
// - Single-ended output straps set its default frequency; open means 19.44MHz.
// - Differential output straps set its default frequency; open means 38.88MHz.
// - Differential output mode comes from the 2-bit signal-format field.
// - 8kHz output defaults to square noninverted; invert and pulse bits alter it.
// - 2kHz output defaults to square noninverted; own invert and pulse bits.
// - After release, ref-fail pin mirrors failure status when enabled, else floats.
// - After release, lock pin shows lock when enabled, else drives low.
// - After release, three diff strap pins act as GPIO with direction and value.
//
// The implementer's own choices: the APB register port and the register offsets.
`default_nettype none
module slsp_strap_pins
  import slsp_pkg::*;
#(
  parameter int FS8K_PERIOD = FS8K_CYCLES,
  parameter int FS2K_PERIOD = FS2K_CYCLES
) (
  // Clock, reset, clock enable
  input wire logic i_clk,
  input wire logic i_reset,
  input wire logic i_ce,
  // APB slave
  input wire logic i_psel,
  input wire logic i_penable,
  input wire logic i_pwrite,
  input wire logic [7:0] i_paddr,
  input wire logic [31:0] i_pwdata,
  output logic [31:0] o_prdata,
  output logic o_pready,
  output logic o_pslverr,
  // Pins
  input wire logic i_source_switch_in,
  input wire logic [2:0] i_input_freq_straps,
  input wire logic [2:0] i_se_out_freq_straps,
  output logic o_ref_fail_pin,
  output logic o_ref_fail_pin_oe,
  output logic o_lock_pin,
  output logic o_lock_pin_oe,
  input wire logic [2:0] i_diff_out_freq_straps,
  output logic [2:0] o_gp_pin,
  output logic [2:0] o_gp_pin_oe,
  output logic o_frame_pulse_8k_out,
  output logic o_multiframe_pulse_2k_out,
  // Core status and configuration
  input wire logic i_selected_ref_failed,
  input wire logic i_dpll_locked,
  output logic o_ref_select_a,
  output logic [3:0] o_input_freq_code_a,
  output logic [3:0] o_input_freq_code_b,
  output logic [2:0] o_se_out_freq_code,
  output logic [2:0] o_diff_out_freq_code,
  output logic [1:0] o_diff_signal_format,
  // Interrupt
  output logic o_irq
);
  if (FS8K_PERIOD < 2 || FS2K_PERIOD < 2) begin : g_chk
    $error("Frame-sync periods must be at least 2 cycles");
  end

  // Two-stage synchronisers for every pin input
  localparam int NSYNC = 10;
  logic [NSYNC-1:0] pin_raw;
  logic [NSYNC-1:0] sync1_r;
  logic [NSYNC-1:0] sync2_r;
  logic [2:0] in_straps_s;
  logic [2:0] se_straps_s;
  logic [2:0] diff_straps_s;
  logic source_switch_in_s;

  assign pin_raw = {i_source_switch_in, i_diff_out_freq_straps, i_se_out_freq_straps,
                    i_input_freq_straps};
  assign in_straps_s = sync2_r[2:0];
  assign se_straps_s = sync2_r[5:3];
  assign diff_straps_s = sync2_r[8:6];
  assign source_switch_in_s = sync2_r[9];

  // Left unreset so valid pin levels are ready at the capture edge
  always_ff @(posedge i_clk) begin
    if (i_ce) begin
      sync1_r <= pin_raw;
      sync2_r <= sync1_r;
    end
  end

  // Registers
  logic latched_r, latched_nxt;
  logic [2:0] view_in_r, view_in_nxt;
  logic [2:0] view_se_r, view_se_nxt;
  logic [2:0] view_diff_r, view_diff_nxt;
  logic [3:0] freq_a_r, freq_a_nxt;
  logic [3:0] freq_b_r, freq_b_nxt;
  logic [2:0] se_freq_r, se_freq_nxt;
  logic [2:0] diff_freq_r, diff_freq_nxt;
  logic [1:0] sig_fmt_r, sig_fmt_nxt;
  logic [3:0] fp_cfg_r, fp_cfg_nxt;
  logic rf_pin_en_r, rf_pin_en_nxt;
  logic lock_pin_en_r, lock_pin_en_nxt;
  logic [2:0] gp_dir_r, gp_dir_nxt;
  logic [2:0] gp_out_r, gp_out_nxt;
  logic [1:0] irq_st_r, irq_st_nxt;
  logic [1:0] irq_mask_r, irq_mask_nxt;
  logic prev_fail_r, prev_fail_nxt;
  logic prev_lock_r, prev_lock_nxt;
  logic ref_sel_r, ref_sel_nxt;
  logic [31:0] prdata_r, prdata_nxt;
  logic staged_r, staged_nxt;

  logic setup;
  logic wr;
  logic hit;
  logic [1:0] ev;
  logic [31:0] rd;

  always_comb begin
    hit = 1'b1;
    rd = 32'h0000_0000;
    unique case (i_paddr)
      OFS_INPUT_A_CFG: rd[POS_FREQ_CODE +: 4] = freq_a_r;
      OFS_INPUT_B_CFG: rd[POS_FREQ_CODE +: 4] = freq_b_r;
      OFS_OUT_FREQ_CFG: begin
        rd[POS_SE_FREQ +: 3] = se_freq_r;
        rd[POS_DIFF_FREQ +: 3] = diff_freq_r;
      end
      OFS_MASTER_CFG_H: rd[POS_SIG_FORMAT +: 2] = sig_fmt_r;
      OFS_FRAME_PULSE_CFG: rd[3:0] = fp_cfg_r;
      OFS_MASTER_CFG_J: rd[POS_REF_FAIL_PIN_EN] = rf_pin_en_r;
      OFS_MASTER_CFG_A: rd[POS_LOCK_PIN_EN] = lock_pin_en_r;
      OFS_GP_IO_CONTROL: begin
        rd[POS_GP_DIR +: 3] = gp_dir_r;
        rd[POS_GP_OUT +: 3] = gp_out_r;
      end
      OFS_GP_IO_STATUS: rd[POS_GP_DIR +: 3] = diff_straps_s;
      OFS_MASTER_STATUS_B: begin
        rd[POS_REF_FAILED] = i_selected_ref_failed;
        rd[POS_DPLL_LOCKED] = i_dpll_locked;
      end
      OFS_IRQ_STATUS: rd[1:0] = irq_st_r;
      OFS_IRQ_MASK: rd[1:0] = irq_mask_r;
      OFS_STRAP_VIEW: begin
        rd[POS_VIEW_IN +: 3] = view_in_r;
        rd[POS_VIEW_SE +: 3] = view_se_r;
        rd[POS_VIEW_DIFF +: 3] = view_diff_r;
      end
      default: hit = 1'b0;
    endcase
  end

  // Read data is staged on an enabled edge before pready rises, so a setup
  // cycle frozen by a low clock enable never returns stale data
  assign setup = i_psel && !(i_penable && o_pready);
  // Writes take effect on the edge that ends the access phase
  assign wr = o_pready && i_psel && i_penable && i_pwrite && hit;

  always_comb begin
    latched_nxt = latched_r;
    view_in_nxt = view_in_r;
    view_se_nxt = view_se_r;
    view_diff_nxt = view_diff_r;
    freq_a_nxt = freq_a_r;
    freq_b_nxt = freq_b_r;
    se_freq_nxt = se_freq_r;
    diff_freq_nxt = diff_freq_r;
    sig_fmt_nxt = sig_fmt_r;
    fp_cfg_nxt = fp_cfg_r;
    rf_pin_en_nxt = rf_pin_en_r;
    lock_pin_en_nxt = lock_pin_en_r;
    gp_dir_nxt = gp_dir_r;
    gp_out_nxt = gp_out_r;
    irq_st_nxt = irq_st_r;
    irq_mask_nxt = irq_mask_r;
    prev_fail_nxt = i_selected_ref_failed;
    prev_lock_nxt = i_dpll_locked;
    ref_sel_nxt = source_switch_in_s;
    prdata_nxt = prdata_r;
    staged_nxt = setup;
    ev = 2'h0;
    ev[POS_EV_REF_FAIL] = latched_r && i_selected_ref_failed && !prev_fail_r;
    ev[POS_EV_LOCK_CHANGE] = latched_r && (i_dpll_locked != prev_lock_r);
    if (setup) begin
      prdata_nxt = (!i_pwrite && hit) ? rd : 32'h0000_0000;
    end
    if (wr) begin
      unique case (i_paddr)
        OFS_INPUT_A_CFG: freq_a_nxt = i_pwdata[POS_FREQ_CODE +: 4];
        OFS_INPUT_B_CFG: freq_b_nxt = i_pwdata[POS_FREQ_CODE +: 4];
        OFS_OUT_FREQ_CFG: begin
          se_freq_nxt = i_pwdata[POS_SE_FREQ +: 3];
          diff_freq_nxt = i_pwdata[POS_DIFF_FREQ +: 3];
        end
        OFS_MASTER_CFG_H: sig_fmt_nxt = i_pwdata[POS_SIG_FORMAT +: 2];
        OFS_FRAME_PULSE_CFG: fp_cfg_nxt = i_pwdata[3:0];
        OFS_MASTER_CFG_J: rf_pin_en_nxt = i_pwdata[POS_REF_FAIL_PIN_EN];
        OFS_MASTER_CFG_A: lock_pin_en_nxt = i_pwdata[POS_LOCK_PIN_EN];
        OFS_GP_IO_CONTROL: begin
          gp_dir_nxt = i_pwdata[POS_GP_DIR +: 3];
          gp_out_nxt = i_pwdata[POS_GP_OUT +: 3];
        end
        OFS_IRQ_STATUS: irq_st_nxt = irq_st_r & ~i_pwdata[1:0];
        OFS_IRQ_MASK: irq_mask_nxt = i_pwdata[1:0];
        default: ;
      endcase
    end
    // A new event beats a write-one-to-clear in the same cycle
    irq_st_nxt = irq_st_nxt | ev;
    // One-shot capture; it overrides any write to the four frequency fields landing in that same cycle
    if (!latched_r) begin
      latched_nxt = 1'b1;
      view_in_nxt = in_straps_s;
      view_se_nxt = se_straps_s;
      view_diff_nxt = diff_straps_s;
      freq_a_nxt = {1'b0, in_straps_s};
      freq_b_nxt = {1'b0, in_straps_s};
      se_freq_nxt = se_straps_s;
      diff_freq_nxt = diff_straps_s;
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_reset) begin
      latched_r <= 1'b0;
      view_in_r <= 3'h0;
      view_se_r <= OPEN_SE_FREQ_CODE;
      view_diff_r <= OPEN_DIFF_FREQ_CODE;
      freq_a_r <= 4'h0;
      freq_b_r <= 4'h0;
      se_freq_r <= OPEN_SE_FREQ_CODE;
      diff_freq_r <= OPEN_DIFF_FREQ_CODE;
      sig_fmt_r <= RST_SIG_FORMAT;
      fp_cfg_r <= RST_FRAME_PULSE_CFG;
      rf_pin_en_r <= RST_REF_FAIL_PIN_EN;
      lock_pin_en_r <= RST_LOCK_PIN_EN;
      gp_dir_r <= RST_GP_DIR;
      gp_out_r <= RST_GP_OUT;
      irq_st_r <= 2'h0;
      irq_mask_r <= RST_IRQ_MASK;
      prev_fail_r <= 1'b0;
      prev_lock_r <= 1'b0;
      ref_sel_r <= 1'b0;
      prdata_r <= 32'h0000_0000;
      staged_r <= 1'b0;
    end else if (i_ce) begin
      latched_r <= latched_nxt;
      view_in_r <= view_in_nxt;
      view_se_r <= view_se_nxt;
      view_diff_r <= view_diff_nxt;
      freq_a_r <= freq_a_nxt;
      freq_b_r <= freq_b_nxt;
      se_freq_r <= se_freq_nxt;
      diff_freq_r <= diff_freq_nxt;
      sig_fmt_r <= sig_fmt_nxt;
      fp_cfg_r <= fp_cfg_nxt;
      rf_pin_en_r <= rf_pin_en_nxt;
      lock_pin_en_r <= lock_pin_en_nxt;
      gp_dir_r <= gp_dir_nxt;
      gp_out_r <= gp_out_nxt;
      irq_st_r <= irq_st_nxt;
      irq_mask_r <= irq_mask_nxt;
      prev_fail_r <= prev_fail_nxt;
      prev_lock_r <= prev_lock_nxt;
      ref_sel_r <= ref_sel_nxt;
      prdata_r <= prdata_nxt;
      staged_r <= staged_nxt;
    end
  end

  // APB answer: zero wait states while the clock enable stays high
  assign o_pready = i_ce && staged_r;
  assign o_pslverr = i_psel && i_penable && !hit;
  assign o_prdata = prdata_r;

  // Shared pins stay released until the straps have been captured
  assign o_ref_fail_pin = i_selected_ref_failed;
  assign o_ref_fail_pin_oe = latched_r && rf_pin_en_r;
  assign o_lock_pin = lock_pin_en_r && i_dpll_locked;
  assign o_lock_pin_oe = latched_r;
  assign o_gp_pin = gp_out_r;
  assign o_gp_pin_oe = latched_r ? gp_dir_r : 3'h0;

  assign o_ref_select_a = ref_sel_r;
  assign o_input_freq_code_a = freq_a_r;
  assign o_input_freq_code_b = freq_b_r;
  assign o_se_out_freq_code = se_freq_r;
  assign o_diff_out_freq_code = diff_freq_r;
  assign o_diff_signal_format = sig_fmt_r;
  assign o_irq = |(irq_st_r & irq_mask_r);

  // Frame-sync generators
  slsp_fs_if fs8k ();
  slsp_fs_if fs2k ();
  assign fs8k.ce = i_ce;
  assign fs8k.invert = fp_cfg_r[POS_P8K_INVERT];
  assign fs8k.pulse_mode = fp_cfg_r[POS_P8K_PULSE];
  assign fs2k.ce = i_ce;
  assign fs2k.invert = fp_cfg_r[POS_P2K_INVERT];
  assign fs2k.pulse_mode = fp_cfg_r[POS_P2K_PULSE];

  slsp_frame_gen #(.PERIOD_CYCLES(FS8K_PERIOD)) u_fs8k (
    .i_clk(i_clk),
    .i_reset(i_reset),
    .fs(fs8k)
  );
  slsp_frame_gen #(.PERIOD_CYCLES(FS2K_PERIOD)) u_fs2k (
    .i_clk(i_clk),
    .i_reset(i_reset),
    .fs(fs2k)
  );
  assign o_frame_pulse_8k_out = fs8k.sync_out;
  assign o_multiframe_pulse_2k_out = fs2k.sync_out;
endmodule : slsp_strap_pins
`default_nettype wire

// ---- slsp_pkg_unused_guard.sv ----
// Intentionally empty: holds no code
`default_nettype none
`default_nettype wire

// ---- slsp_strap_pins_assertions.sv ----
// Port-level checker for the strap latch and status pin block
`default_nettype none
module slsp_strap_pins_assertions
  import slsp_pkg::*;
(
  // Clock, reset, bus
  input wire logic i_clk,
  input wire logic i_reset,
  input wire logic i_ce,
  input wire logic i_psel,
  input wire logic i_penable,
  input wire logic i_pwrite,
  input wire logic [7:0] i_paddr,
  input wire logic [31:0] i_pwdata,
  input wire logic o_pready,
  // Pins and status
  input wire logic i_source_switch_in,
  input wire logic i_selected_ref_failed,
  input wire logic i_dpll_locked,
  input wire logic o_ref_fail_pin,
  input wire logic o_ref_fail_pin_oe,
  input wire logic o_lock_pin,
  input wire logic o_lock_pin_oe,
  input wire logic [2:0] o_gp_pin,
  input wire logic [2:0] o_gp_pin_oe,
  input wire logic o_ref_select_a,
  input wire logic [3:0] o_input_freq_code_a,
  input wire logic [3:0] o_input_freq_code_b,
  input wire logic [2:0] o_se_out_freq_code,
  input wire logic o_irq
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking cb @(posedge i_clk);
  endclocking
  logic [31:0] wdata_r;
  always_ff @(posedge i_clk) wdata_r <= i_pwdata;

  chk_reset_quiet: assert property (i_reset |=> !o_ref_fail_pin_oe && !o_lock_pin_oe
    && o_gp_pin_oe == 3'h0 && !o_irq && o_se_out_freq_code == OPEN_SE_FREQ_CODE)
    else $error("outputs not at defaults in reset");
  chk_codes_capture: assert property (disable iff (i_reset) $fell(i_reset) |=>
    o_input_freq_code_a == o_input_freq_code_b && !o_input_freq_code_a[3])
    else $error("input codes differ after capture");
  chk_straps_held: assert property (disable iff (i_reset) !$past(i_reset) &&
    !(i_psel && i_penable && i_pwrite && i_paddr == OFS_OUT_FREQ_CFG) |=> $stable(o_se_out_freq_code))
    else $error("latched code moved");
  chk_fail_mirror: assert property (disable iff (i_reset)
    o_ref_fail_pin_oe |-> o_ref_fail_pin == i_selected_ref_failed)
    else $error("ref-fail pin not mirroring");
  chk_lock_oe: assert property (disable iff (i_reset) $fell(i_reset) |=> o_lock_pin_oe)
    else $error("lock pin not driven after release");
  chk_lock_value: assert property (disable iff (i_reset) o_lock_pin |-> i_dpll_locked)
    else $error("lock pin high while unlocked");
  chk_gp_write: assert property (disable iff (i_reset) i_psel && i_penable && o_pready &&
    i_pwrite && i_paddr == OFS_GP_IO_CONTROL && !$past(i_reset)
    |=> o_gp_pin_oe == wdata_r[2:0] && o_gp_pin == wdata_r[6:4])
    else $error("gpio control not applied");
  chk_select_high: assert property (disable iff (i_reset)
    (i_ce && i_source_switch_in) [*4] |=> o_ref_select_a)
    else $error("input A not selected");
  chk_select_low: assert property (disable iff (i_reset)
    (i_ce && !i_source_switch_in) [*4] |=> !o_ref_select_a)
    else $error("input B not selected");
endmodule // slsp_strap_pins_assertions

bind slsp_strap_pins slsp_strap_pins_assertions i_chk (.i_clk, .i_reset, .i_ce, .i_psel,
  .i_penable, .i_pwrite, .i_paddr, .i_pwdata, .o_pready, .i_source_switch_in,
  .i_selected_ref_failed, .i_dpll_locked, .o_ref_fail_pin, .o_ref_fail_pin_oe, .o_lock_pin,
  .o_lock_pin_oe, .o_gp_pin, .o_gp_pin_oe, .o_ref_select_a, .o_input_freq_code_a,
  .o_input_freq_code_b, .o_se_out_freq_code, .o_irq);
`default_nettype wire

// ---- slsp_board_model.sv ----
// Board model: strap resistors and external drivers on the shared pins
`default_nettype none
module slsp_board_model (
  // Strap levels and external drive
  input wire logic [8:0] i_straps,
  input wire logic [2:0] i_gp_ext,
  input wire logic [2:0] i_gp_ext_en,
  // Device drivers
  input wire logic [1:0] i_stat_pin,
  input wire logic [1:0] i_stat_oe,
  input wire logic [2:0] i_gp_pin,
  input wire logic [2:0] i_gp_oe,
  // Pin levels seen by the device
  output logic [2:0] o_in_straps,
  output logic [2:0] o_se_straps,
  output logic [2:0] o_diff_straps
);
  timeunit 1ns;
  timeprecision 1ns;
  // A strap resistor only sets the level while nobody drives the pin
  assign o_in_straps = i_straps[2:0];
  assign o_se_straps[0] = i_straps[3];
  assign o_se_straps[1] = i_stat_oe[0] ? i_stat_pin[0] : i_straps[4];
  assign o_se_straps[2] = i_stat_oe[1] ? i_stat_pin[1] : i_straps[5];
  always_comb begin
    for (int k = 0; k < 3; k++) begin
      o_diff_straps[k] = i_gp_oe[k] ? i_gp_pin[k] :
        (i_gp_ext_en[k] ? i_gp_ext[k] : i_straps[6 + k]);
    end
  end
endmodule // slsp_board_model
`default_nettype wire

// ---- slsp_strap_pins_test.sv ----
// Self-checking bench for the strap latch and status pin block
`default_nettype none
module slsp_strap_pins_test
  import slsp_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  localparam int P8 = 8;
  localparam int P2 = 16;
  int ex8[4] = '{P2 / 2, P2 / 2, P2 / P8, P2 - P2 / P8};
  int ex2[4] = '{P2 / 2, P2 / 2, 1, P2 - 1};
  logic i_clk = 1'b0, i_reset = 1'b1, i_ce = 1'b1, i_psel = 1'b0, i_penable = 1'b0;
  logic i_pwrite = 1'b0, i_source_switch_in = 1'b0, i_selected_ref_failed = 1'b0;
  logic i_dpll_locked = 1'b0, o_pready, o_pslverr, o_ref_fail_pin, o_ref_fail_pin_oe;
  logic o_lock_pin, o_lock_pin_oe, o_frame_pulse_8k_out, o_multiframe_pulse_2k_out;
  logic o_ref_select_a, o_irq;
  logic [7:0] i_paddr = 8'h00;
  logic [31:0] i_pwdata = 32'h0, o_prdata, seed = 32'h0166C865;
  logic [2:0] i_input_freq_straps, i_se_out_freq_straps, i_diff_out_freq_straps, o_gp_pin;
  logic [2:0] o_gp_pin_oe, o_se_out_freq_code, o_diff_out_freq_code;
  logic [2:0] gp_ext = 3'h0, gp_ext_en = 3'h0;
  logic [3:0] o_input_freq_code_a, o_input_freq_code_b;
  logic [1:0] o_diff_signal_format;
  logic [8:0] straps = 9'h118, cap;
  logic [32:0] exp_q[$];
  int fails = 0, n_checks = 0;

  slsp_strap_pins #(.FS8K_PERIOD(P8), .FS2K_PERIOD(P2)) i_dut (.i_clk, .i_reset, .i_ce,
    .i_psel, .i_penable, .i_pwrite, .i_paddr, .i_pwdata, .o_prdata, .o_pready, .o_pslverr,
    .i_source_switch_in, .i_input_freq_straps, .i_se_out_freq_straps, .o_ref_fail_pin,
    .o_ref_fail_pin_oe, .o_lock_pin, .o_lock_pin_oe, .i_diff_out_freq_straps, .o_gp_pin,
    .o_gp_pin_oe, .o_frame_pulse_8k_out, .o_multiframe_pulse_2k_out, .i_selected_ref_failed,
    .i_dpll_locked, .o_ref_select_a, .o_input_freq_code_a, .o_input_freq_code_b,
    .o_se_out_freq_code, .o_diff_out_freq_code, .o_diff_signal_format, .o_irq);
  slsp_board_model i_board (.i_straps(straps), .i_gp_ext(gp_ext), .i_gp_ext_en(gp_ext_en),
    .i_stat_pin({o_lock_pin, o_ref_fail_pin}), .i_stat_oe({o_lock_pin_oe, o_ref_fail_pin_oe}),
    .i_gp_pin(o_gp_pin), .i_gp_oe(o_gp_pin_oe), .o_in_straps(i_input_freq_straps),
    .o_se_straps(i_se_out_freq_straps), .o_diff_straps(i_diff_out_freq_straps));

  always #25 i_clk = ~i_clk;

  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction

  task automatic check(input logic [32:0] seen, input logic [32:0] want);
    n_checks++;
    if (seen !== want) begin
      fails++;
      $display("unexpected at %0t: got %h, want %h", $time, seen, want);
    end
  endtask

  task automatic tally_and_finish();
    $display("checks %0d, mismatches %0d", n_checks, fails);
    if (fails == 0 && n_checks > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask

  // Read expectations wait in the queue until the access cycle shows the data
  task automatic apb(input logic wr, input logic [7:0] a, input logic [32:0] d);
    @(posedge i_clk);
    i_psel <= 1'b1;
    i_penable <= 1'b0;
    i_pwrite <= wr;
    i_paddr <= a;
    i_pwdata <= wr ? d[31:0] : 32'h0;
    if (!wr) exp_q.push_back(d);
    @(posedge i_clk);
    i_penable <= 1'b1;
    do @(posedge i_clk); while (o_pready !== 1'b1);
    i_psel <= 1'b0;
    i_penable <= 1'b0;
    @(negedge i_clk);
  endtask

  always @(posedge i_clk) begin
    if (i_psel && i_penable && o_pready && !i_pwrite) begin
      if (exp_q.size() == 0) check(1, 0);
      else check({o_pslverr, o_prdata}, exp_q.pop_front());
    end
  end

  task automatic do_reset(input logic [8:0] s);
    @(posedge i_clk);
    straps <= s;
    i_reset <= 1'b1;
    repeat (15) @(posedge i_clk);
    @(negedge i_clk);
    check({o_input_freq_code_a, o_se_out_freq_code, o_diff_out_freq_code},
      {4'h0, OPEN_SE_FREQ_CODE, OPEN_DIFF_FREQ_CODE});
    @(posedge i_clk);
    i_reset <= 1'b0;
    // The first edge after release captures the straps
    @(posedge i_clk);
    @(negedge i_clk);
  endtask

  task automatic frame_check(input int m, input logic two);
    int h;
    apb(1'b1, OFS_FRAME_PULSE_CFG, two ? m << 2 : m);
    // Sample mid-cycle; the cycle of the write edge still shows the old setting
    if (!two) begin
      while (o_multiframe_pulse_2k_out !== 1'b0) @(negedge i_clk);
      while (o_multiframe_pulse_2k_out !== 1'b1) @(negedge i_clk);
      check(o_frame_pulse_8k_out, !m[0]);
    end else begin
      @(negedge i_clk);
    end
    h = 0;
    repeat (P2) begin
      h += two ? o_multiframe_pulse_2k_out : o_frame_pulse_8k_out;
      @(negedge i_clk);
    end
    check(h, two ? ex2[m] : ex8[m]);
  endtask

  initial begin
    #500000;
    fails++;
    tally_and_finish();
  end

  initial begin
    do_reset(9'h118);
    check({o_se_out_freq_code, o_diff_out_freq_code},
      {OPEN_SE_FREQ_CODE, OPEN_DIFF_FREQ_CODE});
    seed = lfsr(seed);
    cap = seed[8:0];
    do_reset(cap);
    check(o_input_freq_code_a, {1'b0, cap[2:0]});
    check(o_input_freq_code_b, {1'b0, cap[2:0]});
    check({o_se_out_freq_code, o_diff_out_freq_code}, {cap[5:3], cap[8:6]});
    apb(1'b0, OFS_STRAP_VIEW, {22'h0, cap[8:6], 1'b0, cap[5:3], 1'b0, cap[2:0]});
    @(posedge i_clk);
    straps <= ~cap;
    repeat (4) @(posedge i_clk);
    apb(1'b0, OFS_INPUT_B_CFG, cap[2:0]);
    check(o_diff_out_freq_code, cap[8:6]);
    for (int k = 0; k < 4; k++) begin
      @(posedge i_clk);
      i_source_switch_in <= k[0];
      repeat (5) @(posedge i_clk);
      @(negedge i_clk);
      check(o_ref_select_a, k[0]);
      apb(1'b1, OFS_MASTER_CFG_H, k);
      apb(1'b0, OFS_MASTER_CFG_H, k);
      check(o_diff_signal_format, k[1:0]);
    end
    check(o_ref_fail_pin_oe, 1'b0);
    apb(1'b1, OFS_MASTER_CFG_J, 1);
    @(posedge i_clk);
    i_selected_ref_failed <= 1'b1;
    i_dpll_locked <= 1'b1;
    @(negedge i_clk);
    check({o_ref_fail_pin_oe, i_se_out_freq_straps[1]}, 2'b11);
    check({o_lock_pin_oe, o_lock_pin}, 2'b10);
    apb(1'b1, OFS_MASTER_CFG_A, 1);
    check({o_lock_pin_oe, i_se_out_freq_straps[2]}, 2'b11);
    apb(1'b0, OFS_MASTER_STATUS_B, 3);
    repeat (3) begin
      seed = lfsr(seed);
      @(posedge i_clk);
      gp_ext <= seed[10:8];
      gp_ext_en <= ~seed[2:0];
      apb(1'b1, OFS_GP_IO_CONTROL, {seed[6:4], 1'b0, seed[2:0]});
      check({o_gp_pin_oe, o_gp_pin}, {seed[2:0], seed[6:4]});
      repeat (3) @(posedge i_clk);
      apb(1'b0, OFS_GP_IO_STATUS, seed[2:0] & seed[6:4] | ~seed[2:0] & seed[10:8]);
    end
    for (int m = 0; m < 8; m++) frame_check(m % 4, m > 3);
    apb(1'b1, OFS_IRQ_STATUS, 3);
    apb(1'b0, OFS_IRQ_STATUS, 0);
    @(posedge i_clk);
    i_selected_ref_failed <= 1'b0;
    @(posedge i_clk);
    i_selected_ref_failed <= 1'b1;
    repeat (3) @(posedge i_clk);
    apb(1'b0, OFS_IRQ_STATUS, 1);
    check(o_irq, 1'b0);
    apb(1'b1, OFS_IRQ_MASK, 1);
    check(o_irq, 1'b1);
    apb(1'b1, OFS_IRQ_STATUS, 1);
    check(o_irq, 1'b0);
    apb(1'b1, 8'h3C, 1);
    apb(1'b0, 8'h3C, 33'h100000000);
    // Clock enable low across the setup cycle: the read must wait, not return stale data
    fork
      begin
        @(posedge i_clk);
        i_ce <= 1'b0;
        repeat (3) @(posedge i_clk);
        i_ce <= 1'b1;
      end
      apb(1'b0, OFS_IRQ_MASK, 1);
    join
    tally_and_finish();
  end
endmodule // slsp_strap_pins_test
`default_nettype wire
